// >>> logic/iow_watchdog.sv
// Independent oscillator watchdog with Wishbone register access
//
// Behaviour
// - 11-bit prescaler feeds software-visible 8-bit count
// - Prescaler runs on private nominal 1 MHz oscillator
// - Count advances once per 2048 oscillator periods
// - Overflow resets chip, pin pulse 16x2048 periods
// - Pin driven high while watchdog reset lasts
// - Internal reset happens even with pin held low
// - Reset forces ports 1-3 high, port 0 float
// - One control register at index A5 governs it
// - Control A5 stops oscillator outside reset pulse, clears prescaler, count
// - Every reset loads control with A5
// - Other control values enable independent counting
// - Count reads return live value, counting continues
// - Count write accepted only when control holds 5A
// - Accepted count write clears prescaler and control
// - Overflow time is (256 - count) x 2048 periods
// - Watchdog reset ends power-down like pin reset
`timescale 1ns/1ps
module iow_watchdog
   import iow_pkg::*;
#(
   parameter int PULSE_TICKS_P = PULSE_TICKS  // Reset pulse, oscillator periods
) (
   input  wire logic  clock,
   input  wire logic  rst_n,
   input  iow_wb_req_t wb_req,
   output iow_wb_rsp_t wb_rsp,
   input  wire logic  rst_pin_in,
   output logic       rst_pin_out,
   output logic       rst_pin_oe,
   output logic       chip_reset,
   output logic [2:0] port_high,
   output logic       port0_float
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////////
   iow_wb_rsp_t  wb_rsp_reg;      // Registered bus answer
   logic [31:0]  rd_data;         // Read mux output
   logic [9:0]   reg_idx;         // Word index of the access
   logic         req_hit;         // Request present
   logic         wr_fire;         // Write completes this edge
   logic         ctrl_wr;         // Control write completes
   logic         cnt_wr;          // Count write completes
   logic         cnt_load;        // Count write accepted
   logic [7:0]   ctrl_reg;        // Watchdog control
   logic [10:0]  pre_reg;         // Prescaler
   logic [7:0]   cnt_reg;         // Watchdog count
   logic [15:0]  pulse_reg;       // Remaining reset pulse periods
   logic [4:0]   ext_reg;         // Pin high run length
   logic         ext_hit;         // Pin reset qualified
   logic         halted;          // Control holds halt value
   logic         osc_run;         // Oscillator enable
   logic         osc_tick;        // One oscillator period elapsed
   logic         pre_wrap;        // Prescaler wraps this tick
   logic         overflow;        // Count overflows this tick
   logic         pulse_done;      // Reset pulse finished
   logic         reset_next;      // Chip reset in next cycle
   iow_state_t   state_reg;       // Current state
   iow_state_t   state_next;      // Next state
   logic         chip_reset_reg;  // Chip reset output flop
   logic         rst_pin_oe_reg;  // Pin drive enable flop
   logic         rst_pin_out_reg; // Pin drive level flop
   logic [2:0]   port_high_reg;   // Ports 1 to 3 forced high
   logic         port0_float_reg; // Port 0 released

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // Private oscillator
   ////////////////////////////////////////////////////////////////////////////
   // Runs while enabled, and through the reset pulse it times
   assign osc_run = !halted || (state_reg == ST_PULSE);

   // Single clock here: the oscillator is a tick, so crossings are exact
   iow_osc #(
      .DIV (OSC_DIV)
   ) u_osc (
      .clock    (clock),
      .rst_n    (rst_n),
      .run      (osc_run),
      .osc_tick (osc_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave
   ////////////////////////////////////////////////////////////////////////////
   assign reg_idx = wb_req.adr[11:2];
   assign req_hit = wb_req.cyc && wb_req.stb;
   // Write acts at the edge where the master sees ack
   assign wr_fire = req_hit && wb_req.we && wb_rsp_reg.ack && wb_req.sel[0];
   // Writes are ignored while the chip sits in watchdog reset
   assign ctrl_wr = wr_fire && (reg_idx == CTRL_IDX) && (state_reg != ST_PULSE);
   assign cnt_wr  = wr_fire && (reg_idx == COUNT_IDX) && (state_reg != ST_PULSE);
   // Count write only through the unlock value
   assign cnt_load = cnt_wr && (ctrl_reg == CTRL_UNLOCK);

   // Read mux
   always_comb begin
      if (reg_idx == CTRL_IDX) begin
         // Control reads back as written
         rd_data = {24'h00_0000, ctrl_reg};
      end else if (reg_idx == COUNT_IDX) begin
         // Live count, counting is not disturbed
         rd_data = {24'h00_0000, cnt_reg};
      end else begin
         // Unmapped reads as zero
         rd_data = 32'h0000_0000;
      end
   end

   // One wait state, ack for one cycle, then dropped
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wb_rsp_reg <= '0;
      end else begin
         wb_rsp_reg.ack <= req_hit && !wb_rsp_reg.ack;
         wb_rsp_reg.dat <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin reset detector
   ////////////////////////////////////////////////////////////////////////////
   // Pin sampled only while not driven by us, so the pulse cannot extend itself
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext_reg <= 5'h00;
      end else if (rst_pin_in && !rst_pin_oe_reg) begin
         // Count high cycles, saturating
         if (ext_reg != EXT_RST_CYCLES) begin
            ext_reg <= ext_reg + 5'h01;
         end
      end else begin
         ext_reg <= 5'h00;
      end
   end

   // Two machine cycles high qualify a pin reset
   assign ext_hit = (ext_reg == EXT_RST_CYCLES) && rst_pin_in && !rst_pin_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   ////////////////////////////////////////////////////////////////////////////
   assign halted = (ctrl_reg == CTRL_HALT);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         // Starts disabled
         ctrl_reg <= CTRL_HALT;
      end else if (overflow || ext_hit) begin
         // Any reset reloads the halt value
         ctrl_reg <= CTRL_HALT;
      end else if (cnt_load) begin
         // Relock after accepted reload, stays enabled
         ctrl_reg <= CTRL_CLEARED;
      end else if (ctrl_wr) begin
         ctrl_reg <= wb_req.dat[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pre_reg <= PRE_RESET;
      end else if (halted || ext_hit) begin
         // Held clear while halted
         pre_reg <= PRE_RESET;
      end else if (cnt_load) begin
         // Reload restarts the interval
         pre_reg <= PRE_RESET;
      end else if (osc_tick) begin
         // Wraps after 2048 periods
         pre_reg <= pre_reg + 11'h001;
      end
   end

   assign pre_wrap = osc_tick && (pre_reg == PRE_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog count
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_reg <= COUNT_RESET;
      end else if (halted || ext_hit) begin
         // Held clear while halted
         cnt_reg <= COUNT_RESET;
      end else if (cnt_load) begin
         // Load wins over a coinciding tick
         cnt_reg <= wb_req.dat[7:0];
      end else if (pre_wrap) begin
         // One step per prescaler wrap, FF wraps to 00 on overflow
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // Overflow only from a running, unreloaded count
   assign overflow = pre_wrap && (cnt_reg == COUNT_LAST) && !cnt_load && !halted
                     && !ext_hit && (state_reg == ST_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Reset pulse timer
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pulse_reg <= 16'(PULSE_TICKS_P - 1);
      end else if (state_reg != ST_PULSE) begin
         // Armed with full length
         pulse_reg <= 16'(PULSE_TICKS_P - 1);
      end else if (osc_tick) begin
         // Timed by the private oscillator
         pulse_reg <= pulse_reg - 16'h0001;
      end
   end

   assign pulse_done = (state_reg == ST_PULSE) && osc_tick && (pulse_reg == 16'h0000);

   ////////////////////////////////////////////////////////////////////////////
   // State machine
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_HALT: begin
            // Any non-halt value enables
            if (!halted) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (overflow) begin
               state_next = ST_PULSE;
            end else if (halted) begin
               state_next = ST_HALT;
            end
         end
         ST_PULSE: begin
            // Control is back at halt when the pulse ends
            if (pulse_done) begin
               state_next = ST_HALT;
            end
         end
         default: begin
            state_next = ST_HALT;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= ST_HALT;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset outputs
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog reset ignores the pin level; pin reset joins it
   assign reset_next = (state_next == ST_PULSE) || ext_hit;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         chip_reset_reg  <= 1'b0;
         rst_pin_oe_reg  <= 1'b0;
         rst_pin_out_reg <= 1'b0;
         port_high_reg   <= 3'h0;
         port0_float_reg <= 1'b0;
      end else begin
         // Whole chip reset, also ends power-down
         chip_reset_reg  <= reset_next;
         // Pin pulled high for the watchdog pulse only
         rst_pin_oe_reg  <= (state_next == ST_PULSE);
         rst_pin_out_reg <= 1'b1;
         // Port states during reset
         port_high_reg   <= {3{reset_next}};
         port0_float_reg <= reset_next;
      end
   end

   assign wb_rsp      = wb_rsp_reg;
   assign chip_reset  = chip_reset_reg;
   assign rst_pin_oe  = rst_pin_oe_reg;
   assign rst_pin_out = rst_pin_out_reg;
   assign port_high   = port_high_reg;
   assign port0_float = port0_float_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   ////////////////////////////////////////////////////////////////////////////
   a_ctrl_reset_val: assert property ($rose(rst_n) |-> ctrl_reg == CTRL_HALT)
      else $error("control not A5 after reset");

   a_halt_clears: assert property (halted ##1 halted
                                   |-> pre_reg == PRE_RESET && cnt_reg == COUNT_RESET)
      else $error("prescaler or count not held clear");

   // A pin reset in the same cycle clears the count, so it is left out
   a_locked_write: assert property (cnt_wr && ctrl_reg != CTRL_UNLOCK
                                    && !halted && !pre_wrap && !ext_hit |=> $stable(cnt_reg))
      else $error("locked count write changed count");

   a_unlock_load: assert property (cnt_load && !ext_hit
                                   |=> cnt_reg == $past(wb_req.dat[7:0])
                                   && ctrl_reg == CTRL_CLEARED)
      else $error("accepted count write did not load and relock");

   a_load_clr_pre: assert property (cnt_load && !ext_hit
                                    |=> pre_reg == PRE_RESET && !halted)
      else $error("accepted count write did not clear prescaler");

   a_count_step: assert property (pre_wrap && !halted && !cnt_load && !ext_hit
                                  |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("count did not step on prescaler wrap");

   a_count_hold: assert property (!pre_wrap && !cnt_load && !halted && !ext_hit
                                  |=> $stable(cnt_reg))
      else $error("count moved without a wrap");

   a_overflow_rst: assert property (overflow
                                    |=> chip_reset && rst_pin_oe && state_reg == ST_PULSE
                                    ##1 chip_reset)
      else $error("overflow did not start the reset pulse");

   a_pin_drive: assert property (state_reg == ST_PULSE
                                 |-> rst_pin_oe && rst_pin_out && chip_reset)
      else $error("reset pin not driven during pulse");

   a_ports_reset: assert property (chip_reset |-> port_high == 3'h7 && port0_float)
      else $error("port states wrong during reset");

   a_wb_ack: assert property (req_hit && !wb_rsp_reg.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
      else $error("bus ack not single cycle");

endmodule

// >>> inc/iow_pkg.sv
// Shared constants and types of the independent oscillator watchdog
package iow_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   ////////////////////////////////////////////////////////////////////////////
   localparam int CLK_PERIOD_NS   = 100;   // System clock period
   localparam int OSC_PERIOD_NS   = 1000;  // Nominal private oscillator period
   // System clocks per oscillator period, rounded up
   localparam int OSC_DIV         = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_WIDTH       = 11;    // Prescaler width
   localparam int CNT_WIDTH       = 8;     // Watchdog count width
   localparam int PULSE_PRESCALES = 16;    // Reset pulse in prescaler periods
   // Reset pulse in oscillator periods
   localparam int PULSE_TICKS     = PULSE_PRESCALES * (2 ** PRE_WIDTH);
   // Pin reset qualify time: two machine cycles of system clock
   localparam logic [4:0] EXT_RST_CYCLES = 5'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte address is four times the index)
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [9:0] CTRL_IDX  = 10'h0a5;  // Watchdog control
   localparam logic [9:0] COUNT_IDX = 10'h0ff;  // Watchdog count

   ////////////////////////////////////////////////////////////////////////////
   // Register values
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]  CTRL_HALT    = 8'ha5;   // Halted, also reset value
   localparam logic [7:0]  CTRL_UNLOCK  = 8'h5a;   // Count write unlocked
   localparam logic [7:0]  CTRL_CLEARED = 8'h00;   // After accepted count write
   localparam logic [7:0]  COUNT_RESET  = 8'h00;   // Count reset value
   localparam logic [10:0] PRE_RESET    = 11'h000; // Prescaler reset value
   localparam logic [10:0] PRE_LAST     = 11'h7ff; // Prescaler wrap point
   localparam logic [7:0]  COUNT_LAST   = 8'hff;   // Count overflow point

   ////////////////////////////////////////////////////////////////////////////
   // Types
   ////////////////////////////////////////////////////////////////////////////
   // Wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } iow_wb_req_t;

   // Wishbone answer to the master
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } iow_wb_rsp_t;

   // Watchdog state, one-hot
   typedef enum logic [2:0] {
      ST_HALT  = 3'b001,
      ST_RUN   = 3'b010,
      ST_PULSE = 3'b100
   } iow_state_t;

endpackage

// >>> logic/iow_osc.sv
// Private oscillator model: a stoppable tick divided from the system clock
`timescale 1ns/1ps
module iow_osc
   import iow_pkg::*;
#(
   parameter int DIV = OSC_DIV  // Clocks per oscillator period
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      osc_tick
);

   logic [7:0] phase_reg;  // Position inside one oscillator period

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // Divider, held at phase zero while stopped
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n || !run) begin
         // Stopped oscillator gives no ticks
         phase_reg <= 8'h00;
         osc_tick  <= 1'b0;
      end else if (phase_reg == 8'(DIV - 1)) begin
         // End of period
         phase_reg <= 8'h00;
         osc_tick  <= 1'b1;
      end else begin
         phase_reg <= phase_reg + 8'h01;
         osc_tick  <= 1'b0;
      end
   end

   // Stopped oscillator stays silent
   a_osc_stopped: assert property (!run |=> !osc_tick)
      else $error("oscillator ticked while stopped");

endmodule

// >>> dv/test_iow_watchdog.sv
// Self-checking testbench of the independent oscillator watchdog
`timescale 1ns/1ps
module test_iow_watchdog
   import iow_pkg::*;
;
   localparam int PULSE = 4;                              // Short reset pulse, osc periods
   localparam logic [11:0] CTRL_ADR  = {CTRL_IDX, 2'b00};  // Control byte address
   localparam logic [11:0] COUNT_ADR = {COUNT_IDX, 2'b00}; // Count byte address
   logic        clock;        // System clock
   logic        rst_n;        // Synchronous reset
   logic        rst_pin_in;   // Reset pin level seen
   logic        rst_pin_out;  // Reset pin drive level
   logic        rst_pin_oe;   // Reset pin drive enable
   logic        chip_reset;   // Whole-chip reset
   logic [2:0]  port_high;    // Ports 1..3 forced high
   logic        port0_float;  // Port 0 released
   iow_wb_req_t wb_req;       // Bus request
   iow_wb_rsp_t wb_rsp;       // Bus answer
   int          errors;       // Mismatches
   int          compares;     // Comparisons
   int          n;            // Loop counter
   int          el;           // Elapsed clocks
   time         t0;           // Start of a timed run
   logic [31:0] seed;         // Random state
   logic [7:0]  v;            // Random control value

   iow_watchdog #(.PULSE_TICKS_P(PULSE)) i_dut (
      .clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .chip_reset(chip_reset), .port_high(port_high), .port0_float(port0_float));

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clock = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   // Xorshift random step
   function automatic logic [31:0] nxt(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Clocks from a count load to overflow
   function automatic int ovf_clocks(input logic [7:0] c);
      return (256 - int'(c)) * (2 ** PRE_WIDTH) * OSC_DIV;
   endfunction
   // Closing report, ends the run
   task automatic print_verdict();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Mismatch report
   task automatic fail(input string msg);
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   // Byte compare
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
   endtask
   // Bit compare
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask
   // One classic bus cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] wd,
                     output logic [7:0] rdat);
      int k;
      @(posedge clock);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr, dat: {24'h0, wd}};
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (wb_rsp.ack !== 1'b1 && k < 16);
      if (wb_rsp.ack !== 1'b1) begin
         fail("bus timeout");
         print_verdict();
      end
      rdat = wb_rsp.dat[7:0];
      wb_req <= '0;
   endtask
   // Register write
   task automatic wr(input logic [11:0] adr, input logic [7:0] d);
      logic [7:0] x;
      wb(1'b1, adr, d, x);
   endtask
   // Register read and compare
   task automatic rd_chk(input logic [11:0] adr, input logic [7:0] exp, input string msg);
      logic [7:0] x;
      wb(1'b0, adr, 8'h00, x);
      chk_byte(x, exp, msg);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      wb_req     = '0;
      rst_n      = 1'b0;
      rst_pin_in = 1'b0;
      errors     = 0;
      compares   = 0;
      seed       = 32'h0000_4014;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      // Reset state, halted, unmapped and locked accesses
      rd_chk(CTRL_ADR, CTRL_HALT, "ctrl reset");
      rd_chk(COUNT_ADR, COUNT_RESET, "count reset");
      wait_clk(300);
      rd_chk(COUNT_ADR, COUNT_RESET, "halted count");
      wr(12'h010, CTRL_UNLOCK);
      rd_chk(12'h010, 8'h00, "unmapped read");
      rd_chk(CTRL_ADR, CTRL_HALT, "unmapped write");
      wr(COUNT_ADR, 8'h33);
      rd_chk(COUNT_ADR, COUNT_RESET, "halted load");
      $display("test basic done");
      // Random control values and count loads
      for (int i = 0; i < 6; i++) begin
         seed = nxt(seed);
         v = seed[7:0];
         if (v == CTRL_HALT || v == CTRL_UNLOCK) v = v ^ 8'h11;
         wr(CTRL_ADR, v);
         rd_chk(CTRL_ADR, v, "ctrl rw");
         wr(COUNT_ADR, seed[15:8]);
         rd_chk(COUNT_ADR, COUNT_RESET, "locked load");
         wr(CTRL_ADR, CTRL_UNLOCK);
         wr(COUNT_ADR, seed[15:8]);
         rd_chk(COUNT_ADR, seed[15:8], "load");
         rd_chk(CTRL_ADR, CTRL_CLEARED, "ctrl cleared");
         wr(COUNT_ADR, ~seed[15:8]);
         rd_chk(COUNT_ADR, seed[15:8], "relocked");
         wr(CTRL_ADR, CTRL_HALT);
         rd_chk(COUNT_ADR, COUNT_RESET, "halt clears");
      end
      $display("test random done");
      // Count advance, live read and overflow time
      wr(CTRL_ADR, CTRL_UNLOCK);
      wr(COUNT_ADR, 8'hfe);
      t0 = $time;
      wait_clk(ovf_clocks(8'hff) - 3 * OSC_DIV);
      rd_chk(COUNT_ADR, 8'hfe, "live read");
      wait_clk(6 * OSC_DIV);
      rd_chk(COUNT_ADR, 8'hff, "count step");
      n = 0;
      while (chip_reset !== 1'b1 && n < ovf_clocks(8'hff)) begin
         @(posedge clock);
         n++;
      end
      // Distance from the expected overflow time, in clocks
      el = int'(($time - t0) / CLK_PERIOD_NS) - ovf_clocks(8'hfe);
      chk_bit(el >= -3 * OSC_DIV && el <= 3 * OSC_DIV, 1'b1, "overflow time");
      chk_bit(chip_reset, 1'b1, "reset, pin low");
      if (chip_reset !== 1'b1) print_verdict();
      chk_bit(rst_pin_oe, 1'b1, "pin driven");
      chk_bit(rst_pin_out, 1'b1, "pin high");
      chk_byte({5'h00, port_high}, 8'h07, "ports high");
      chk_bit(port0_float, 1'b1, "port0 float");
      // Control write during the pulse must be dropped
      wr(CTRL_ADR, 8'h3c);
      n = 0;
      while (chip_reset === 1'b1 && n < 1000) begin
         @(posedge clock);
         n++;
      end
      // The bus write above used three clocks of the pulse
      n = n + 3 - PULSE * OSC_DIV;
      chk_bit(n >= -OSC_DIV && n <= OSC_DIV, 1'b1, "pulse length");
      chk_bit(chip_reset, 1'b0, "pulse ends");
      if (chip_reset !== 1'b0) print_verdict();
      chk_bit(rst_pin_oe, 1'b0, "pin released");
      rd_chk(CTRL_ADR, CTRL_HALT, "ctrl after wdt");
      rd_chk(COUNT_ADR, COUNT_RESET, "count after wdt");
      $display("test overflow done");
      // Pin reset
      wr(CTRL_ADR, CTRL_UNLOCK);
      rst_pin_in <= 1'b1;
      wait_clk(30);
      chk_bit(chip_reset, 1'b1, "pin reset");
      rst_pin_in <= 1'b0;
      n = 0;
      while (chip_reset !== 1'b0 && n < 100) begin
         @(posedge clock);
         n++;
      end
      chk_bit(chip_reset, 1'b0, "pin reset ends");
      if (chip_reset !== 1'b0) print_verdict();
      rd_chk(CTRL_ADR, CTRL_HALT, "ctrl after pin");
      $display("test pin reset done");
      print_verdict();
   end

   // Fixed wait in clocks
   task automatic wait_clk(input int c);
      repeat (c) @(posedge clock);
   endtask
endmodule
